// >>> rtl/charger_regs_defines.vh
// Purpose: constants for the charger timer, thermal, misc and status register bank
// Assumes: 8-bit registers behind the serial engine's internal register port
// Notes:   definitions only
`ifndef CHARGER_REGS_DEFINES_VH
`define CHARGER_REGS_DEFINES_VH

// register offsets
`define ADDR_TERM_TIMER     8'h05
`define ADDR_THERMAL        8'h06
`define ADDR_MISC           8'h07
`define ADDR_STATUS         8'h08

// reset values
`define RST_TERM_TIMER      8'h9A
`define RST_THERMAL         8'h03
`define RST_MISC            8'h4B
`define RD_UNMAPPED         8'h00

// termination/timer register fields
`define TT_TERM_EN          7
`define TT_TERM_IND         6
`define TT_WDOG_HI          5
`define TT_WDOG_LO          4
`define TT_TIMER_EN         3
`define TT_DUR_HI           2
`define TT_DUR_LO           1

// thermal register field
`define TH_THR_HI           1
`define TH_THR_LO           0

// misc register fields
`define MI_FORCE_DET        7
`define MI_SLOWDOWN         6
`define MI_BATSW_DIS        5
`define MI_INT_CHG          1
`define MI_INT_BAT          0

// charge state codes
`define CS_IDLE             2'h0
`define CS_PRE              2'h1
`define CS_FAST             2'h2
`define CS_DONE             2'h3

// watchdog periods in seconds, code 00 disables
`define WDOG_OFF            2'h0
`define WDOG_S1             40
`define WDOG_S2             80
`define WDOG_S3             160

// safety timer durations in hours
`define DUR_H0              5
`define DUR_H1              8
`define DUR_H2              12
`define DUR_H3              20
`define SEC_PER_HOUR        3600

// timebase: the counters run in half-second ticks
`define HALF_TICK_MS        500
`define CLK_PERIOD_NS       100
`define HALF_TICK_CYCLES    (`HALF_TICK_MS * 1000000 / `CLK_PERIOD_NS)
`define TICKS_PER_SEC       2
`define TICK_STEP_FULL      2'h2
`define TICK_STEP_HALF      2'h1

`endif

// >>> rtl/charger_timer_misc_status_regs.v
// Purpose: termination/timer, thermal, misc control and system status registers
// Assumes: serial engine presents one-cycle read/write strobes on clk_sys
// Notes:   status reads are live; safety and watchdog timers use a half-second tick
//
// How it works
// - termination enable bit, read/write, resets enabled, drives term_enable
// - indicator bit selects early status-high below 800 mA instead of normal
// - two-bit watchdog field: off, 40 s, 80 s, 160 s; resets to 40 s
// - safety timer runs only when enabled; 5/8/12/20 hours, resets 8 hours
// - two-bit thermal threshold: 60, 80, 100, 120 C; resets to 120 C
// - writing one forces port detection; self-clears when detection completes
// - slowdown bit halves safety timer rate during power limiting or thermal regulation
// - battery switch disable bit forces battery path transistor off
// - charge fault pulses interrupt only when its enable bit is set
// - battery fault pulses interrupt only when its enable bit is set
// - control registers reset to 9A, 03 and 4B
// - read-only status: source type, charge state, power-good flag and three regulation flags
// - source type codes: unknown, USB host, adapter, boost output
// - charge state codes: idle, pre-charge, fast charge, done
`timescale 1ns/1ns
`include "charger_regs_defines.vh"

module charger_timer_misc_status_regs #(
    parameter HALF_TICK_CYCLES = `HALF_TICK_CYCLES
) (
    input  wire       clk_sys,
    input  wire       reset,
    // register port from the serial engine
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // charger core status
    input  wire [1:0] input_source_type,
    input  wire [1:0] charge_state,
    input  wire       power_limit_active,
    input  wire       power_good_flag,
    input  wire       thermal_reg_active,
    input  wire       min_system_regulation_active,
    input  wire       current_below_800ma,
    input  wire       detection_done,
    input  wire       charge_fault,
    input  wire       battery_fault,
    // settings and events toward the charger core
    output reg        term_enable,
    output reg        charge_status_high,
    output reg  [1:0] thermal_regulation_threshold,
    output reg        force_port_detection,
    output reg        battery_path_transistor_off,
    output reg        interrupt_pulse,
    output reg        watchdog_expired,
    output reg        safety_timer_expired
);

    reg  [7:0]  term_timer_reg;
    reg  [7:0]  thermal_reg;
    reg  [7:0]  misc_reg;
    reg  [31:0] tick_cnt_reg;
    reg  [9:0]  wdog_cnt_reg;
    reg  [18:0] safety_cnt_reg;
    wire        half_tick;
    wire [7:0]  status_live;
    wire        host_access;
    wire        charging;
    wire        slowed;
    wire [9:0]  wdog_limit;
    wire [18:0] safety_limit;
    wire [18:0] safety_step;

    // limits held as 32-bit constants so they can be cut to counter width on purpose
    localparam [31:0] WDOG_T1 = `WDOG_S1 * `TICKS_PER_SEC;
    localparam [31:0] WDOG_T2 = `WDOG_S2 * `TICKS_PER_SEC;
    localparam [31:0] WDOG_T3 = `WDOG_S3 * `TICKS_PER_SEC;
    // safety limits in quarter-second units: a full-rate half-second tick adds two
    localparam [31:0] DUR_T0  = `DUR_H0 * `SEC_PER_HOUR * `TICKS_PER_SEC * `TICK_STEP_FULL;
    localparam [31:0] DUR_T1  = `DUR_H1 * `SEC_PER_HOUR * `TICKS_PER_SEC * `TICK_STEP_FULL;
    localparam [31:0] DUR_T2  = `DUR_H2 * `SEC_PER_HOUR * `TICKS_PER_SEC * `TICK_STEP_FULL;
    localparam [31:0] DUR_T3  = `DUR_H3 * `SEC_PER_HOUR * `TICKS_PER_SEC * `TICK_STEP_FULL;
    localparam [7:0]  TT_INIT = `RST_TERM_TIMER;
    localparam [7:0]  TH_INIT = `RST_THERMAL;

    // watchdog period in half-second ticks
    function [9:0] wdog_ticks;
        input [1:0] code;
        begin
            case (code)
                2'h1:    wdog_ticks = WDOG_T1[9:0];
                2'h2:    wdog_ticks = WDOG_T2[9:0];
                2'h3:    wdog_ticks = WDOG_T3[9:0];
                default: wdog_ticks = 10'h000;
            endcase
        end
    endfunction

    // safety duration in quarter-second units; 20 hours needs the nineteenth bit
    function [18:0] dur_ticks;
        input [1:0] code;
        begin
            case (code)
                2'h0:    dur_ticks = DUR_T0[18:0];
                2'h1:    dur_ticks = DUR_T1[18:0];
                2'h2:    dur_ticks = DUR_T2[18:0];
                default: dur_ticks = DUR_T3[18:0];
            endcase
        end
    endfunction

    // live status word, nothing latched so a read sees the present state
    assign status_live = {input_source_type, charge_state, power_limit_active,
                          power_good_flag, thermal_reg_active,
                          min_system_regulation_active};

    assign host_access  = reg_wr | reg_rd;
    assign charging     = (charge_state == `CS_PRE) || (charge_state == `CS_FAST);
    assign slowed       = misc_reg[`MI_SLOWDOWN] &
                          (power_limit_active | thermal_reg_active);
    assign wdog_limit   = wdog_ticks(term_timer_reg[`TT_WDOG_HI:`TT_WDOG_LO]);
    assign safety_limit = dur_ticks(term_timer_reg[`TT_DUR_HI:`TT_DUR_LO]);
    assign half_tick    = (tick_cnt_reg == HALF_TICK_CYCLES - 1);
    // half step while slowed keeps the timer at half rate without a second divider
    assign safety_step  = slowed ? {17'h00000, `TICK_STEP_HALF} :
                                   {17'h00000, `TICK_STEP_FULL};

    // control registers; reserved bits stored as written by the host
    always @(posedge clk_sys) begin
        if (reset) begin
            term_timer_reg <= `RST_TERM_TIMER;
            thermal_reg    <= `RST_THERMAL;
            misc_reg       <= `RST_MISC;
        end else begin
            if (reg_wr && reg_addr == `ADDR_TERM_TIMER) begin
                term_timer_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ADDR_THERMAL) begin
                thermal_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ADDR_MISC) begin
                misc_reg <= reg_wdata;
            end else if (detection_done) begin
                // a host write in the same cycle wins, so a new request is kept
                misc_reg[`MI_FORCE_DET] <= 1'b0;
            end
        end
    end

    // read data registered one cycle after the strobe; unmapped reads zero
    always @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= `RD_UNMAPPED;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_TERM_TIMER: reg_rdata <= term_timer_reg;
                `ADDR_THERMAL:    reg_rdata <= thermal_reg;
                `ADDR_MISC:       reg_rdata <= misc_reg;
                `ADDR_STATUS:     reg_rdata <= status_live;
                default:          reg_rdata <= `RD_UNMAPPED;
            endcase
        end
    end

    // shared half-second prescaler
    always @(posedge clk_sys) begin
        if (reset || half_tick) begin
            tick_cnt_reg <= 32'h00000000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
        end
    end

    // host-link watchdog, restarted by any register access
    always @(posedge clk_sys) begin
        if (reset) begin
            wdog_cnt_reg     <= 10'h000;
            watchdog_expired <= 1'b0;
        end else begin
            watchdog_expired <= 1'b0;
            if (host_access || wdog_limit == 10'h000) begin
                wdog_cnt_reg <= 10'h000;
            end else if (half_tick) begin
                if (wdog_cnt_reg + 10'h001 >= wdog_limit) begin
                    wdog_cnt_reg     <= 10'h000;
                    watchdog_expired <= 1'b1;
                end else begin
                    wdog_cnt_reg <= wdog_cnt_reg + 10'h001;
                end
            end
        end
    end

    // pre-charge and fast-charge safety timer; quarter-second units so slowdown adds one not two
    always @(posedge clk_sys) begin
        if (reset) begin
            safety_cnt_reg       <= 19'h00000;
            safety_timer_expired <= 1'b0;
        end else if (!term_timer_reg[`TT_TIMER_EN] || !charging) begin
            safety_cnt_reg       <= 19'h00000;
            safety_timer_expired <= 1'b0;
        end else if (half_tick && !safety_timer_expired) begin
            safety_cnt_reg <= safety_cnt_reg + safety_step;
            // test the advanced count so the flag rises on the last tick, not one later
            if (safety_cnt_reg + safety_step >= safety_limit) begin
                safety_timer_expired <= 1'b1;
            end
        end
    end

    // settings out and event outputs, all registered
    always @(posedge clk_sys) begin
        if (reset) begin
            term_enable                  <= TT_INIT[`TT_TERM_EN];
            charge_status_high           <= 1'b0;
            thermal_regulation_threshold <= TH_INIT[`TH_THR_HI:`TH_THR_LO];
            force_port_detection         <= 1'b0;
            battery_path_transistor_off  <= 1'b0;
            interrupt_pulse              <= 1'b0;
        end else begin
            term_enable <= term_timer_reg[`TT_TERM_EN];
            // early mode goes high in fast charge once current drops below 800 mA
            charge_status_high <= (charge_state == `CS_DONE) ||
                                  (term_timer_reg[`TT_TERM_IND] &&
                                   charge_state == `CS_FAST &&
                                   current_below_800ma);
            thermal_regulation_threshold <= thermal_reg[`TH_THR_HI:`TH_THR_LO];
            force_port_detection         <= misc_reg[`MI_FORCE_DET];
            battery_path_transistor_off  <= misc_reg[`MI_BATSW_DIS];
            interrupt_pulse <= (charge_fault & misc_reg[`MI_INT_CHG]) |
                               (battery_fault & misc_reg[`MI_INT_BAT]);
        end
    end

endmodule

// >>> verif/charger_timer_misc_status_regs_asserts.sv
// Purpose: port checks of the charger register bank
// Assumes: one clock, synchronous reset
// Notes:   bound to the design below
`timescale 1ns/1ns
`include "charger_regs_defines.vh"
module regs_checker #(
    parameter HALF_TICK_CYCLES = 4
) (
    input wire       clk_sys,
    input wire       reset,
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire [1:0] input_source_type,
    input wire [1:0] charge_state,
    input wire       power_limit_active,
    input wire       power_good_flag,
    input wire       thermal_reg_active,
    input wire       min_system_regulation_active,
    input wire       detection_done,
    input wire       charge_fault,
    input wire       battery_fault,
    input wire       term_enable,
    input wire       charge_status_high,
    input wire [1:0] thermal_regulation_threshold,
    input wire       force_port_detection,
    input wire       battery_path_transistor_off,
    input wire       interrupt_pulse,
    input wire       watchdog_expired
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // shadow of the two interrupt enables, tracked from host writes
    reg [1:0] int_en_reg;
    always @(posedge clk_sys) begin
        if (reset) begin
            int_en_reg <= 2'h3;
        end else if (reg_wr && reg_addr == `ADDR_MISC) begin
            int_en_reg <= reg_wdata[1:0];
        end
    end
    // settings show two edges after the write strobe
    sequence s_wr(a); reg_wr && reg_addr == a; endsequence
    property p_rst; $fell(reset) |-> term_enable && thermal_regulation_threshold == 2'h3
        && !force_port_detection && !battery_path_transistor_off; endproperty
    a_rst: assert property (p_rst) else $error("bad outputs after reset");
    property p_term; s_wr(`ADDR_TERM_TIMER) |-> ##2
        term_enable == $past(reg_wdata[7], 2); endproperty
    a_term: assert property (p_term) else $error("term enable not written");
    property p_thr; s_wr(`ADDR_THERMAL) |-> ##2
        thermal_regulation_threshold == $past(reg_wdata[1:0], 2); endproperty
    a_thr: assert property (p_thr) else $error("threshold not written");
    property p_bsw; s_wr(`ADDR_MISC) |-> ##2
        battery_path_transistor_off == $past(reg_wdata[5], 2); endproperty
    a_bsw: assert property (p_bsw) else $error("switch disable not written");
    // a write in the same cycle wins over completion
    property p_det; detection_done && !(reg_wr && reg_addr == `ADDR_MISC)
        |-> ##2 !force_port_detection; endproperty
    a_det: assert property (p_det) else $error("force bit not cleared");
    property p_sts; reg_rd && reg_addr == `ADDR_STATUS |=> reg_rdata == $past({input_source_type,
        charge_state, power_limit_active, power_good_flag, thermal_reg_active,
        min_system_regulation_active}); endproperty
    a_sts: assert property (p_sts) else $error("status read not live");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_int; interrupt_pulse |->
        $past((charge_fault && int_en_reg[1]) || (battery_fault && int_en_reg[0])); endproperty
    a_int: assert property (p_int) else $error("interrupt without enabled fault");
    property p_irq; (charge_fault && int_en_reg[1]) || (battery_fault && int_en_reg[0])
        |=> interrupt_pulse; endproperty
    a_irq: assert property (p_irq) else $error("enabled fault gave no interrupt");
    property p_done; charge_state == `CS_DONE |=> charge_status_high; endproperty
    a_done: assert property (p_done) else $error("status low when done");
    property p_wdog; watchdog_expired |=> !watchdog_expired; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog pulse too long");
endmodule
bind charger_timer_misc_status_regs regs_checker
    #(.HALF_TICK_CYCLES(HALF_TICK_CYCLES)) regs_checker_inst (.*);

// >>> verif/host_model.sv
// Purpose: host side of the internal register port
// Assumes: strobes taken on rising clk_sys
// Notes:   released lines show scrambled values
`timescale 1ns/1ns
module host_model (
    input  wire       clk_sys,
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg  [7:0] reg_wdata,
    output reg        reg_rd,
    input  wire [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // one byte write, callers keep reserved bits legal
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
            reg_addr <= ~a;
            reg_wdata <= ~d;
        end
    endtask
    // read data lands one edge after the strobe is taken
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            reg_addr <= ~a;
            // data was launched one edge earlier and holds, so this edge is safe
            @(posedge clk_sys);
            d = reg_rdata;
        end
    endtask
endmodule

// >>> verif/charger_timer_misc_status_regs_test.sv
// Purpose: register bank bench
// Assumes: half-second tick on every clock so whole timer periods fit the run
// Notes:   safety timer run is the long one
`timescale 1ns/1ns
`include "charger_regs_defines.vh"
module charger_timer_misc_status_regs_test;
    reg        clk_sys = 1'b0;
    reg        reset = 1'b1;
    reg  [7:0] st = 8'h00;
    reg        lo_cur = 1'b0;
    reg        det = 1'b0;
    reg        cf = 1'b0;
    reg        bf = 1'b0;
    wire [7:0] addr, wdata, rdata;
    wire       wr, rd, ten, shi, frc, bsw, irq, wdg, sft;
    wire [1:0] thr;
    reg  [7:0] got;
    integer    errors = 0;
    integer    checks_done = 0;
    integer    i, n;
    always #50 clk_sys = ~clk_sys;
    host_model host_model_inst (.clk_sys(clk_sys), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));
    charger_timer_misc_status_regs #(.HALF_TICK_CYCLES(1)) charger_timer_misc_status_regs_inst (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_rdata(rdata), .input_source_type(st[7:6]), .charge_state(st[5:4]),
        .power_limit_active(st[3]), .power_good_flag(st[2]), .thermal_reg_active(st[1]),
        .min_system_regulation_active(st[0]), .current_below_800ma(lo_cur),
        .detection_done(det), .charge_fault(cf), .battery_fault(bf), .term_enable(ten),
        .charge_status_high(shi), .thermal_regulation_threshold(thr),
        .force_port_detection(frc), .battery_path_transistor_off(bsw), .interrupt_pulse(irq),
        .watchdog_expired(wdg), .safety_timer_expired(sft));
    task chk(input [63:0] what, input [7:0] exp, input [7:0] seen);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            host_model_inst.rd(a, got);
            chk("rdata", exp, got);
        end
    endtask
    // fault seen at one edge, interrupt registered from it
    task fault(input c, input b, input e);
        begin
            @(posedge clk_sys);
            cf <= c;
            bf <= b;
            @(posedge clk_sys);
            cf <= 1'b0;
            bf <= 1'b0;
            #1 chk("irq", {7'h0, e}, {7'h0, irq});
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rdc(`ADDR_TERM_TIMER, `RST_TERM_TIMER);
        rdc(`ADDR_THERMAL, `RST_THERMAL);
        rdc(`ADDR_MISC, `RST_MISC);
        rdc(8'h09, `RD_UNMAPPED);
        for (i = 0; i < 4; i = i + 1) begin
            host_model_inst.wr(`ADDR_THERMAL, i[7:0]);
            rdc(`ADDR_THERMAL, i[7:0]);
            chk("thr", i[7:0], {6'h0, thr});
            st <= {i[1:0], ~i[1:0], i[1:0], ~i[1:0]};
            host_model_inst.wr(`ADDR_STATUS, 8'h00);
            rdc(`ADDR_STATUS, st);
        end
        $display("test fields done");
        host_model_inst.wr(`ADDR_MISC, 8'hA8);
        rdc(`ADDR_MISC, 8'hA8);
        chk("sw_frc", 8'h03, {6'h0, bsw, frc});
        det <= 1'b1;
        @(posedge clk_sys);
        det <= 1'b0;
        rdc(`ADDR_MISC, 8'h28);
        chk("frc", 8'h00, {7'h0, frc});
        fault(1'b1, 1'b0, 1'b0);
        fault(1'b0, 1'b1, 1'b0);
        host_model_inst.wr(`ADDR_MISC, 8'h0B);
        fault(1'b1, 1'b0, 1'b1);
        fault(1'b0, 1'b1, 1'b1);
        $display("test misc done");
        @(posedge clk_sys);
        lo_cur <= 1'b1;
        st <= {2'h0, `CS_FAST, 4'h0};
        host_model_inst.wr(`ADDR_TERM_TIMER, 8'h40);
        repeat (2) @(posedge clk_sys);
        #1 chk("early", 8'h01, {6'h0, ten, shi});
        // 40 s is 80 half-second ticks, one tick per clock here
        host_model_inst.wr(`ADDR_TERM_TIMER, 8'h10);
        for (n = 0; n < 400 && wdg !== 1'b1; n = n + 1)
            @(posedge clk_sys) #1;
        chk("wdog", 8'h01, {7'h0, n > 75 && n < 85});
        #1 chk("normal", 8'h00, {7'h0, shi});
        // 5 hours is 36000 half-second ticks at full rate
        host_model_inst.wr(`ADDR_TERM_TIMER, 8'h08);
        for (n = 0; n < 37000 && sft !== 1'b1; n = n + 1)
            @(posedge clk_sys) #1;
        chk("safety", 8'h01, {7'h0, n > 35990 && n < 36010});
        host_model_inst.wr(`ADDR_TERM_TIMER, 8'h00);
        host_model_inst.wr(`ADDR_MISC, 8'h4B);
        chk("stop", 8'h00, {7'h0, sft});
        // 20000 ticks in thermal regulation count as 10000, so 26000 more are needed
        st <= {2'h0, `CS_FAST, 4'h2};
        host_model_inst.wr(`ADDR_TERM_TIMER, 8'h08);
        repeat (20000) @(posedge clk_sys);
        st <= {2'h0, `CS_FAST, 4'h0};
        for (n = 20000; n < 47000 && sft !== 1'b1; n = n + 1)
            @(posedge clk_sys) #1;
        chk("slowed", 8'h01, {7'h0, n > 45990 && n < 46010});
        $display("test timers done");
        wrap_up;
    end
endmodule
